// file: core/second_order_comb_stage.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - as sync master, reading or writing the oscillator frequency word forces a sync that zeroes the phase.
// - as sync slave, frequency word accesses create no internal sync.
// - a frequency write made as slave leaves a sync pending that fires as master at the next phase wrap through zero.
// - a new I/Q sample is taken on every cycle that in_valid is high, with no stall.
// - the ratio (1 to 16) gives one output per ratio-many input samples.
// - I and Q are filtered in parallel lanes and leave one after the other on one output path.
// - each lane has two integrators and two combs with differential delay one.
// - scale 0 to 6 divides the result by two per step with an arithmetic right shift.
// - the scale still applies when the filter is bypassed.
// - as master the sync pin is driven with pulses, as slave it is sampled every rising edge.
// - as slave the phase is held at zero while the sync pin is high.

module second_order_comb_stage (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // classic wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [second_order_comb_stage_pkg::ADR_W-1:0]    wb_adr_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic [31:0]                   wb_dat_i,
  output logic [31:0]                        wb_dat_o,
  output logic                               wb_ack_o,
  // oscillator sync pin
  input  wire logic                          oscillator_sync_pin_i,
  output logic                               oscillator_sync_pin_o,
  output logic                               oscillator_sync_pin_oe,
  // oscillator phase towards the mixer
  output logic [second_order_comb_stage_pkg::PHASE_W-1:0]       nco_phase,
  // mixed samples in
  input  wire logic                          in_valid,
  input  wire logic [second_order_comb_stage_pkg::DATA_W-1:0]   in_i,
  input  wire logic [second_order_comb_stage_pkg::DATA_W-1:0]   in_q,
  // decimated samples out to the fifth order comb stage
  output logic                               out_valid,
  output logic                               out_is_q,
  output logic [second_order_comb_stage_pkg::ACC_W-1:0]         out_data
);

  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  logic                          ack_r,    ack_nxt;
  logic [31:0]                   rdat_r,   rdat_nxt;
  logic                          master_r, master_nxt;
  logic [second_order_comb_stage_pkg::PHASE_W-1:0]  oscillator_frequency_word_r;
  logic [second_order_comb_stage_pkg::PHASE_W-1:0]  oscillator_frequency_word_nxt;
  logic [second_order_comb_stage_pkg::RATIO_W-1:0]  comb2_decimation_ratio_r;
  logic [second_order_comb_stage_pkg::RATIO_W-1:0]  comb2_decimation_ratio_nxt;
  logic [second_order_comb_stage_pkg::SCALE_W-1:0]  comb2_scale_factor_r;
  logic [second_order_comb_stage_pkg::SCALE_W-1:0]  comb2_scale_factor_nxt;
  logic                          take;
  logic                          take_freq;
  logic                          take_decim;
  logic [31:0]                   status_word;

  logic                          pend_r, pend_nxt;
  logic [second_order_comb_stage_pkg::PHASE_W-1:0]  phase_r, phase_nxt;
  logic                          spulse_r, spulse_nxt;
  logic                          slave_hold;

  logic [second_order_comb_stage_pkg::RATIO_W-1:0]  cnt_r, cnt_nxt;
  logic                          dump;
  logic                          bypass;

  // the request is taken on the edge where the master sees ack high
  assign take       = wb_cyc_i && wb_stb_i && ack_r;
  assign take_freq  = take && (wb_adr_i == second_order_comb_stage_pkg::ADDR_FREQ);
  assign take_decim = take && wb_we_i && (wb_adr_i == second_order_comb_stage_pkg::ADDR_DECIM);
  assign slave_hold = !master_r && oscillator_sync_pin_i;

  always_comb begin
    status_word = '0;
    status_word[second_order_comb_stage_pkg::STATUS_PEND_BIT] = pend_r;
    status_word[second_order_comb_stage_pkg::STATUS_HOLD_BIT] = slave_hold;
    status_word[second_order_comb_stage_pkg::STATUS_CNT_LSB +: second_order_comb_stage_pkg::RATIO_W] = cnt_r;
  end

  always_comb begin
    ack_nxt  = wb_cyc_i && wb_stb_i && !ack_r;
    rdat_nxt = rdat_r;
    if (ack_nxt) begin
      unique case (wb_adr_i)
        second_order_comb_stage_pkg::ADDR_CTRL: begin
          rdat_nxt = '0;
          rdat_nxt[second_order_comb_stage_pkg::CTRL_MASTER_BIT] = master_r;
        end
        second_order_comb_stage_pkg::ADDR_FREQ: begin
          rdat_nxt = oscillator_frequency_word_r;
        end
        second_order_comb_stage_pkg::ADDR_DECIM: begin
          rdat_nxt = '0;
          rdat_nxt[second_order_comb_stage_pkg::DECIM_RATIO_LSB +: second_order_comb_stage_pkg::RATIO_W] =
            comb2_decimation_ratio_r;
          rdat_nxt[second_order_comb_stage_pkg::DECIM_SCALE_LSB +: second_order_comb_stage_pkg::SCALE_W] =
            comb2_scale_factor_r;
        end
        second_order_comb_stage_pkg::ADDR_STATUS: begin
          rdat_nxt = status_word;
        end
        second_order_comb_stage_pkg::ADDR_PHASE: begin
          rdat_nxt = phase_r;
        end
        default: begin
          rdat_nxt = '0;
        end
      endcase
    end
  end

  always_comb begin
    logic [31:0] m;
    m                             = '0;
    master_nxt                    = master_r;
    oscillator_frequency_word_nxt = oscillator_frequency_word_r;
    comb2_decimation_ratio_nxt    = comb2_decimation_ratio_r;
    comb2_scale_factor_nxt        = comb2_scale_factor_r;
    if (take && wb_we_i) begin
      if (wb_adr_i == second_order_comb_stage_pkg::ADDR_CTRL && wb_sel_i[0]) begin
        master_nxt = wb_dat_i[second_order_comb_stage_pkg::CTRL_MASTER_BIT];
      end
      if (wb_adr_i == second_order_comb_stage_pkg::ADDR_FREQ) begin
        oscillator_frequency_word_nxt = second_order_comb_stage_pkg::merge_bytes(
          oscillator_frequency_word_r, wb_dat_i, wb_sel_i);
      end
      if (wb_adr_i == second_order_comb_stage_pkg::ADDR_DECIM) begin
        m = second_order_comb_stage_pkg::merge_bytes(
          32'(comb2_decimation_ratio_r) |
          (32'(comb2_scale_factor_r) << second_order_comb_stage_pkg::DECIM_SCALE_LSB),
          wb_dat_i, wb_sel_i);
        // out of range values are clamped rather than refused
        comb2_decimation_ratio_nxt = second_order_comb_stage_pkg::clamp_ratio(
          m[second_order_comb_stage_pkg::DECIM_RATIO_LSB +: second_order_comb_stage_pkg::RATIO_W]);
        comb2_scale_factor_nxt = second_order_comb_stage_pkg::clamp_scale(
          m[second_order_comb_stage_pkg::DECIM_SCALE_LSB +: second_order_comb_stage_pkg::SCALE_W]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ack_r                       <= 1'b0;
      rdat_r                      <= '0;
      master_r                    <= second_order_comb_stage_pkg::MASTER_RST;
      oscillator_frequency_word_r <= second_order_comb_stage_pkg::FREQ_RST;
      comb2_decimation_ratio_r    <= second_order_comb_stage_pkg::RATIO_RST;
      comb2_scale_factor_r        <= second_order_comb_stage_pkg::SCALE_RST;
    end else begin
      ack_r                       <= ack_nxt;
      rdat_r                      <= rdat_nxt;
      master_r                    <= master_nxt;
      oscillator_frequency_word_r <= oscillator_frequency_word_nxt;
      comb2_decimation_ratio_r    <= comb2_decimation_ratio_nxt;
      comb2_scale_factor_r        <= comb2_scale_factor_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ----------------------------------------------------------------------
  // oscillator phase and sync
  // ----------------------------------------------------------------------
  // only the phase accumulator and sync handling live here; the mixer reads nco_phase
  always_comb begin
    logic [second_order_comb_stage_pkg::PHASE_W:0] sum;
    sum        = {1'b0, phase_r} + {1'b0, oscillator_frequency_word_r};
    phase_nxt  = phase_r;
    pend_nxt   = pend_r;
    spulse_nxt = 1'b0;
    if (in_valid) begin
      phase_nxt = sum[second_order_comb_stage_pkg::PHASE_W-1:0];
    end
    if (master_r) begin
      if (take_freq) begin
        phase_nxt  = '0;
        spulse_nxt = 1'b1;
        pend_nxt   = 1'b0;
      end else if (pend_r && in_valid && sum[second_order_comb_stage_pkg::PHASE_W]) begin
        phase_nxt  = '0;
        spulse_nxt = 1'b1;
        pend_nxt   = 1'b0;
      end
    end else begin
      if (take_freq && wb_we_i) begin
        pend_nxt = 1'b1;
      end
      if (slave_hold) begin
        phase_nxt = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      phase_r  <= '0;
      pend_r   <= 1'b0;
      spulse_r <= 1'b0;
    end else begin
      phase_r  <= phase_nxt;
      pend_r   <= pend_nxt;
      spulse_r <= spulse_nxt;
    end
  end

  assign nco_phase              = phase_r;
  assign oscillator_sync_pin_o  = spulse_r;
  assign oscillator_sync_pin_oe = master_r;

  // ----------------------------------------------------------------------
  // decimation count
  // ----------------------------------------------------------------------
  assign bypass = (comb2_decimation_ratio_r == second_order_comb_stage_pkg::RATIO_MIN);
  assign dump   = in_valid &&
                  (cnt_r >= comb2_decimation_ratio_r - 5'h01);

  always_comb begin
    cnt_nxt = cnt_r;
    if (dump) begin
      cnt_nxt = '0;
    end else if (in_valid) begin
      cnt_nxt = cnt_r + 5'h01;
    end
    if (take_decim) begin
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // parallel lanes and I/Q multiplex
  // ----------------------------------------------------------------------
  logic                       i_valid, q_valid;
  logic [second_order_comb_stage_pkg::ACC_W-1:0] i_res,   q_res;
  logic                       ov_r,    ov_nxt;
  logic                       isq_r,   isq_nxt;
  logic                       qpend_r, qpend_nxt;
  logic [second_order_comb_stage_pkg::ACC_W-1:0] od_r,    od_nxt;

  comb2_lane lane_i (
    .clk          (clk),
    .rst          (rst),
    .sample_valid (in_valid),
    .sample       (in_i),
    .dump         (dump),
    .bypass       (bypass),
    .scale        (comb2_scale_factor_r),
    .result_valid (i_valid),
    .result       (i_res)
  );

  comb2_lane lane_q (
    .clk          (clk),
    .rst          (rst),
    .sample_valid (in_valid),
    .sample       (in_q),
    .dump         (dump),
    .bypass       (bypass),
    .scale        (comb2_scale_factor_r),
    .result_valid (q_valid),
    .result       (q_res)
  );

  // a new I result overrides a waiting Q one; only bypass at full input
  // rate can cause that
  always_comb begin
    ov_nxt    = 1'b0;
    isq_nxt   = isq_r;
    od_nxt    = od_r;
    qpend_nxt = 1'b0;
    if (i_valid) begin
      ov_nxt    = 1'b1;
      isq_nxt   = 1'b0;
      od_nxt    = i_res;
      qpend_nxt = q_valid;
    end else if (qpend_r) begin
      ov_nxt  = 1'b1;
      isq_nxt = 1'b1;
      od_nxt  = q_res;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ov_r    <= 1'b0;
      isq_r   <= 1'b0;
      qpend_r <= 1'b0;
      od_r    <= '0;
    end else begin
      ov_r    <= ov_nxt;
      isq_r   <= isq_nxt;
      qpend_r <= qpend_nxt;
      od_r    <= od_nxt;
    end
  end

  assign out_valid = ov_r;
  assign out_is_q  = isq_r;
  assign out_data  = od_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_slave_write;
    take_freq && wb_we_i && !master_r;
  endsequence

  sequence s_wrap_as_master;
    master_r && pend_r && in_valid && !take_freq &&
      ({1'b0, phase_r} + {1'b0, oscillator_frequency_word_r})
        > 33'h0FFFF_FFFF;
  endsequence

  AST_ACCESS_ZEROES_PHASE: assert property (
    take_freq && master_r |=> phase_r == '0 && oscillator_sync_pin_o)
    else $error("frequency access as master did not zero the phase");
  AST_SLAVE_NO_SYNC: assert property (
    s_slave_write |=> !oscillator_sync_pin_o && pend_r)
    else $error("slave frequency write produced a sync");
  AST_WRAP_SYNC: assert property (
    s_wrap_as_master |=> oscillator_sync_pin_o && !pend_r && phase_r == '0)
    else $error("pending sync missed the phase wrap");
  AST_COUNT_EVERY_SAMPLE: assert property (
    in_valid && !dump && !take_decim |=> cnt_r == $past(cnt_r) + 5'h01)
    else $error("sample not counted");
  AST_DUMP_GIVES_OUTPUT: assert property (
    dump |=> i_valid && q_valid ##1 out_valid && !out_is_q)
    else $error("decimation point gave no output");
  AST_Q_FOLLOWS_I: assert property (
    i_valid && q_valid ##1 !i_valid |=> out_valid && out_is_q &&
      out_data == $past(q_res))
    else $error("Q word did not follow I word");
  AST_PIN_DIRECTION: assert property (
    oscillator_sync_pin_oe == master_r &&
      (master_r || !oscillator_sync_pin_o || $past(master_r)))
    else $error("sync pin direction wrong");
  AST_SLAVE_HOLD: assert property (
    slave_hold [*2] |=> phase_r == '0)
    else $error("phase advanced while held by sync pin");
  AST_OUT_FLAGGED: assert property (
    out_valid && out_is_q |-> $past(out_valid) && !$past(out_is_q))
    else $error("Q word without preceding I word");

endmodule

`default_nettype wire

// file: core/second_order_comb_stage_pkg.sv
package second_order_comb_stage_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int DATA_W  = 16;
  localparam int ACC_W   = 24;
  localparam int PHASE_W = 32;
  localparam int RATIO_W = 5;
  localparam int SCALE_W = 3;
  localparam int ADR_W   = 8;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [ADR_W-1:0] ADDR_CTRL   = 8'h00;
  localparam logic [ADR_W-1:0] ADDR_FREQ   = 8'h04;
  localparam logic [ADR_W-1:0] ADDR_DECIM  = 8'h08;
  localparam logic [ADR_W-1:0] ADDR_STATUS = 8'h0C;
  localparam logic [ADR_W-1:0] ADDR_PHASE  = 8'h10;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_MASTER_BIT   = 3;
  localparam int DECIM_RATIO_LSB   = 0;
  localparam int DECIM_SCALE_LSB   = 8;
  localparam int STATUS_PEND_BIT   = 0;
  localparam int STATUS_HOLD_BIT   = 1;
  localparam int STATUS_CNT_LSB    = 4;

  // ----------------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------------
  localparam logic               MASTER_RST = 1'b1;
  localparam logic [PHASE_W-1:0] FREQ_RST   = 32'h0000_0000;
  localparam logic [RATIO_W-1:0] RATIO_MIN  = 5'h01;
  localparam logic [RATIO_W-1:0] RATIO_MAX  = 5'h10;
  localparam logic [RATIO_W-1:0] RATIO_RST  = 5'h02;
  localparam logic [SCALE_W-1:0] SCALE_MAX  = 3'h6;
  localparam logic [SCALE_W-1:0] SCALE_RST  = 3'h0;

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  function automatic logic [RATIO_W-1:0] clamp_ratio(
    input logic [RATIO_W-1:0] r);
    if (r < RATIO_MIN) return RATIO_MIN;
    if (r > RATIO_MAX) return RATIO_MAX;
    return r;
  endfunction

  function automatic logic [SCALE_W-1:0] clamp_scale(
    input logic [SCALE_W-1:0] s);
    return (s > SCALE_MAX) ? SCALE_MAX : s;
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] m;
    m = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) m[8*b +: 8] = new_v[8*b +: 8];
    end
    return m;
  endfunction

  function automatic logic [ACC_W-1:0] widen(input logic [DATA_W-1:0] d);
    return {{(ACC_W-DATA_W){d[DATA_W-1]}}, d};
  endfunction

  function automatic logic [ACC_W-1:0] scale_down(
    input logic [ACC_W-1:0]   v,
    input logic [SCALE_W-1:0] s);
    return ACC_W'($signed(v) >>> s);
  endfunction

endpackage

// file: core/comb2_lane.sv
`timescale 1ns/1ps
`default_nettype none

module comb2_lane (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // sample in
  input  wire logic                        sample_valid,
  input  wire logic [second_order_comb_stage_pkg::DATA_W-1:0] sample,
  input  wire logic                        dump,
  input  wire logic                        bypass,
  input  wire logic [second_order_comb_stage_pkg::SCALE_W-1:0] scale,
  // result out
  output logic                             result_valid,
  output logic [second_order_comb_stage_pkg::ACC_W-1:0]       result
);

  logic [second_order_comb_stage_pkg::ACC_W-1:0] int1_r, int1_nxt;
  logic [second_order_comb_stage_pkg::ACC_W-1:0] int2_r, int2_nxt;
  logic [second_order_comb_stage_pkg::ACC_W-1:0] dly1_r, dly1_nxt;
  logic [second_order_comb_stage_pkg::ACC_W-1:0] dly2_r, dly2_nxt;
  logic [second_order_comb_stage_pkg::ACC_W-1:0] res_r,  res_nxt;
  logic                       rv_r,   rv_nxt;

  // ----------------------------------------------------------------------
  // integrators, combs, scaling
  // ----------------------------------------------------------------------
  // 24 bits hold 16-bit input times 16^2 gain, so wrap never reaches
  // the scaled result
  always_comb begin
    logic [second_order_comb_stage_pkg::ACC_W-1:0] x;
    logic [second_order_comb_stage_pkg::ACC_W-1:0] comb1;
    logic [second_order_comb_stage_pkg::ACC_W-1:0] comb2;
    x        = second_order_comb_stage_pkg::widen(sample);
    comb1    = '0;
    comb2    = '0;
    int1_nxt = int1_r;
    int2_nxt = int2_r;
    dly1_nxt = dly1_r;
    dly2_nxt = dly2_r;
    res_nxt  = res_r;
    rv_nxt   = 1'b0;
    if (sample_valid) begin
      int1_nxt = int1_r + x;
      int2_nxt = int2_r + int1_nxt;
      if (bypass) begin
        res_nxt = second_order_comb_stage_pkg::scale_down(x, scale);
        rv_nxt  = 1'b1;
      end else if (dump) begin
        comb1    = int2_nxt - dly1_r;
        dly1_nxt = int2_nxt;
        comb2    = comb1 - dly2_r;
        dly2_nxt = comb1;
        res_nxt  = second_order_comb_stage_pkg::scale_down(comb2, scale);
        rv_nxt   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      int1_r <= '0;
      int2_r <= '0;
      dly1_r <= '0;
      dly2_r <= '0;
      res_r  <= '0;
      rv_r   <= 1'b0;
    end else begin
      int1_r <= int1_nxt;
      int2_r <= int2_nxt;
      dly1_r <= dly1_nxt;
      dly2_r <= dly2_nxt;
      res_r  <= res_nxt;
      rv_r   <= rv_nxt;
    end
  end

  assign result_valid = rv_r;
  assign result       = res_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  AST_BYPASS_SCALED: assert property (
    @(posedge clk) disable iff (rst)
    sample_valid && bypass |=> result_valid && result ==
      second_order_comb_stage_pkg::scale_down(second_order_comb_stage_pkg::widen($past(sample)), $past(scale)))
    else $error("bypass result not scaled input");

  AST_NO_SAMPLE_NO_RESULT: assert property (
    @(posedge clk) disable iff (rst)
    !sample_valid |=> !result_valid)
    else $error("result without a sample");

endmodule

`default_nettype wire

// file: verif/cic_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// mixer source and fifth order comb sink
// ----------------------------------------
module cic_far_model (
  // control
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [7:0]  count,
  input  wire logic        gap,
  input  wire logic [15:0] xi,
  input  wire logic [15:0] xq,
  // samples out
  output logic             in_valid,
  output logic [15:0]      in_i,
  output logic [15:0]      in_q,
  output logic             busy,
  // results in
  input  wire logic        out_valid,
  input  wire logic        out_is_q,
  input  wire logic [23:0] out_data,
  input  wire logic        sync_o,
  output logic [23:0]      last_i,
  output logic [23:0]      last_q,
  output int               n_i,
  output int               n_q,
  output int               n_sync
);
  logic [7:0] left;
  logic       ph;
  assign busy = (left != 8'h00) || in_valid;
  always_ff @(posedge clk) begin
    in_valid <= 1'b0;
    // idle lines toggle so a stale sample is never mistaken for data
    in_i <= ~in_i;
    in_q <= ~in_q;
    ph <= gap & ~ph;
    if (rst) begin
      left <= 8'h00;
      in_i <= 16'h0000;
      in_q <= 16'h0000;
    end else if (start) begin
      left <= count;
      ph <= 1'b0;
    end else if (left != 8'h00 && !ph) begin
      in_valid <= 1'b1;
      in_i <= xi;
      in_q <= xq;
      left <= left - 8'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      n_i <= 0;
      n_q <= 0;
      n_sync <= 0;
    end else begin
      if (out_valid && out_is_q) begin
        last_q <= out_data;
        n_q <= n_q + 1;
      end
      if (out_valid && !out_is_q) begin
        last_i <= out_data;
        n_i <= n_i + 1;
      end
      if (sync_o) n_sync <= n_sync + 1;
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clk, rst, cyc, stb, we, start, gap, ext_sync, pin;
  logic        ack, pin_o, oe, iv, ov, oq, busy;
  logic [7:0]  adr, count;
  logic [15:0] xi, xq, ii, iq;
  logic [23:0] od, li, lq;
  logic [31:0] wdat, rdat, rd, phase;
  int          n_i, n_q, n_sync, errors, total_checks, cycles, a, b;
  int          r[3] = '{2, 5, 16};
  int          s[3] = '{0, 3, 6};
  assign pin = oe ? pin_o : ext_sync;
  always #20 clk = ~clk;
  second_order_comb_stage dut_u (.clk(clk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .oscillator_sync_pin_i(pin), .oscillator_sync_pin_o(pin_o),
    .oscillator_sync_pin_oe(oe), .nco_phase(phase), .in_valid(iv),
    .in_i(ii), .in_q(iq), .out_valid(ov), .out_is_q(oq), .out_data(od));
  cic_far_model far_u (.clk(clk), .rst(rst), .start(start), .count(count),
    .gap(gap), .xi(xi), .xq(xq), .in_valid(iv), .in_i(ii), .in_q(iq),
    .busy(busy), .out_valid(ov), .out_is_q(oq), .out_data(od),
    .sync_o(pin_o), .last_i(li), .last_q(lq), .n_i(n_i), .n_q(n_q),
    .n_sync(n_sync));
  // ---------------------------------
  // shared tasks
  // ---------------------------------
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // the fixed tail wait covers the I then Q output latency
  task automatic run(input logic [7:0] n, input logic g);
    @(posedge clk);
    count <= n;
    gap <= g;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    while (busy) @(posedge clk);
    repeat (6) @(posedge clk);
  endtask
  // ---------------------------------
  // scenarios
  // ---------------------------------
  task automatic t_reset();
    wb(1'b0, second_order_comb_stage_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h8, rd & 32'h8);
    wb(1'b0, second_order_comb_stage_pkg::ADDR_DECIM, 32'h0);
    chk("decim", 32'h2, rd & 32'h71F);
    wb(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    chk("oe", 32'h1, {31'h0, oe});
  endtask
  task automatic t_decim();
    xi <= 16'h0064;
    xq <= 16'hFFC4;
    // scales keep ratio squared times level inside the word
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, second_order_comb_stage_pkg::ADDR_DECIM, 32'(r[k] + 256 * s[k]));
      a = n_i;
      b = n_q;
      run(8'(8 * r[k]), 1'b0);
      chk("n_i", 32'h8, n_i - a);
      chk("n_q", 32'h8, n_q - b);
      chk("i", ((100 * r[k] * r[k]) >>> s[k]) & 24'hFFFFFF, li);
      chk("q", ((-60 * r[k] * r[k]) >>> s[k]) & 24'hFFFFFF, lq);
    end
  endtask
  task automatic t_bypass();
    wb(1'b1, second_order_comb_stage_pkg::ADDR_DECIM, 32'h0700);
    wb(1'b0, second_order_comb_stage_pkg::ADDR_DECIM, 32'h0);
    chk("clamp", 32'h601, rd & 32'h71F);
    wb(1'b1, second_order_comb_stage_pkg::ADDR_DECIM, 32'h0201);
    a = n_i;
    run(8'd10, 1'b1);
    chk("n_i", 32'd10, n_i - a);
    chk("i", 32'd25, li);
    chk("q", 32'hFFFFF1, lq);
  endtask
  task automatic t_sync();
    // leave bypass so full-rate runs below stay legal
    wb(1'b1, second_order_comb_stage_pkg::ADDR_DECIM, 32'h0000_0002);
    a = n_sync;
    wb(1'b1, second_order_comb_stage_pkg::ADDR_FREQ, 32'h4000_0000);
    repeat (2) @(posedge clk);
    chk("sync", a + 1, n_sync);
    run(8'd3, 1'b0);
    chk("phase", 32'hC000_0000, phase);
    wb(1'b0, second_order_comb_stage_pkg::ADDR_FREQ, 32'h0);
    repeat (2) @(posedge clk);
    chk("sync", a + 2, n_sync);
    chk("phase", 32'h0, phase);
    run(8'd3, 1'b0);
    wb(1'b1, second_order_comb_stage_pkg::ADDR_CTRL, 32'h0);
    @(posedge clk);
    chk("oe", 32'h0, {31'h0, oe});
    wb(1'b1, second_order_comb_stage_pkg::ADDR_FREQ, 32'h4000_0000);
    repeat (2) @(posedge clk);
    chk("sync", a + 2, n_sync);
    chk("phase", 32'hC000_0000, phase);
    wb(1'b0, second_order_comb_stage_pkg::ADDR_STATUS, 32'h0);
    chk("pend", 32'h1, rd & 32'h1);
    wb(1'b1, second_order_comb_stage_pkg::ADDR_CTRL, 32'h8);
    run(8'd1, 1'b0);
    chk("sync", a + 3, n_sync);
    chk("phase", 32'h0, phase);
  endtask
  task automatic t_hold();
    wb(1'b1, second_order_comb_stage_pkg::ADDR_CTRL, 32'h0);
    run(8'd2, 1'b0);
    ext_sync <= 1'b1;
    run(8'd4, 1'b0);
    chk("phase", 32'h0, phase);
    wb(1'b0, second_order_comb_stage_pkg::ADDR_STATUS, 32'h0);
    chk("hold", 32'h2, rd & 32'h2);
    ext_sync <= 1'b0;
    run(8'd1, 1'b0);
    chk("phase", 32'h4000_0000, phase);
  endtask
  // a hang anywhere ends the run as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    {clk, cyc, stb, we, start, gap, ext_sync} = 7'h00;
    {adr, count, xi, xq, wdat} = 80'h0;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_decim();
    t_bypass();
    t_sync();
    t_hold();
    finish_test();
  end
endmodule
`default_nettype wire
